// File: design/sopg_consts.svh
// constants for the sync output pulse generator: offsets, fields, resets, timing
`ifndef SOPG_CONSTS_SVH
`define SOPG_CONSTS_SVH

// command code of the settings frame, little endian on the wire
`define SOPG_CMD_CODE        32'h6f6e7373
// frame lengths in bytes
`define SOPG_REQ_BYTES       5'h10
`define SOPG_ANS_BYTES       3'h4
// bit positions inside the flag byte
`define SOPG_F_FOLLOW        0
`define SOPG_F_FIXED_LEVEL   1
`define SOPG_F_ACTIVE_LOW    2
`define SOPG_F_IN_STEPS      3
`define SOPG_F_ON_BEGIN      4
`define SOPG_F_ON_END        5
`define SOPG_F_ON_PERIOD     6
// field positions in the captured payload (bytes 0..13)
`define SOPG_P_CMD_LSB       0
`define SOPG_P_FLAGS_LSB     32
`define SOPG_P_WIDTH_LSB     40
`define SOPG_P_PERIOD_LSB    56
`define SOPG_P_ACC_LSB       72
`define SOPG_P_UACC_LSB      104
// reset values of the stored settings
`define SOPG_RST_FLAGS       8'h00
`define SOPG_RST_WIDTH       16'h0000
`define SOPG_RST_PERIOD      16'h0000
`define SOPG_RST_ACC         32'h00000000
`define SOPG_RST_UACC        8'h00
// timing: one width unit in time mode and the clock period, both in ns
`define SOPG_WIDTH_UNIT_NS   1000
`define SOPG_CLK_PERIOD_NS   20
`define SOPG_US_CYCLES       (`SOPG_WIDTH_UNIT_NS / `SOPG_CLK_PERIOD_NS)

`endif

// File: design/sopg_pkg.sv
// types shared by the sync output pulse generator files
package sopg_pkg;

	// settings frame receiver states
	typedef enum logic [1:0]
	{
		SOPG_RX_IDLE,
		SOPG_RX_COLLECT,
		SOPG_RX_ECHO
	} sopg_rx_state_e;

endpackage

// File: design/sopg_frame_rx.sv
// settings frame receiver: collects, checks, loads and echoes the command code
`timescale 1ns/1ns
`include "sopg_consts.svh"

module sopg_frame_rx
(
	input  wire logic        clk_sys,       // system clock
	input  wire logic        rst_n,         // async reset, active low
	input  wire logic [7:0]  rx_byte,       // incoming frame byte
	input  wire logic        rx_valid,      // rx_byte is valid this cycle
	input  wire logic        rx_first,      // marks the first byte of a frame
	output logic      [7:0]  tx_byte,       // answer byte
	output logic             tx_valid,      // answer byte valid
	input  wire logic        tx_ready,      // receiver takes the answer byte
	output logic      [7:0]  cfg_flags,     // captured flag byte
	output logic      [15:0] cfg_width,     // captured pulse width
	output logic      [15:0] cfg_period,    // captured period
	output logic      [31:0] cfg_acc,       // captured whole step window
	output logic      [7:0]  cfg_uacc,      // captured microstep window
	output logic             cfg_load       // one cycle: new settings valid
);

	sopg_pkg::sopg_rx_state_e state_reg, state_next;   // receiver state
	logic [4:0]   idx_reg, idx_next;                   // bytes taken so far
	logic [15:0]  sum_reg, sum_next;                   // running checksum
	logic [111:0] data_reg, data_next;                 // payload bytes 0..13
	logic [7:0]   crc_lo_reg, crc_lo_next;             // low checksum byte
	logic [2:0]   echo_reg, echo_next;                 // answer bytes sent
	logic         load_reg, load_next;                 // settings load strobe
	logic [15:0]  crc_rx;                              // received checksum
	logic         tx_valid_reg, tx_valid_next;         // answer byte offered
	logic [7:0]   tx_byte_reg, tx_byte_next;           // answer byte

	assign crc_rx = {rx_byte, crc_lo_reg};

	// next state: collect 16 bytes, verify, then echo the code
	always_comb
	begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		sum_next    = sum_reg;
		data_next   = data_reg;
		crc_lo_next = crc_lo_reg;
		echo_next   = echo_reg;
		load_next   = 1'b0;
		case (state_reg)
			sopg_pkg::SOPG_RX_IDLE, sopg_pkg::SOPG_RX_COLLECT:
			begin
				if (rx_valid && rx_first)
				begin
					// fresh frame: byte 0 starts the payload and the sum
					data_next  = {rx_byte, data_reg[111:8]};
					sum_next   = {8'h00, rx_byte};
					idx_next   = 5'h01;
					state_next = sopg_pkg::SOPG_RX_COLLECT;
				end
				else if (rx_valid && state_reg == sopg_pkg::SOPG_RX_COLLECT)
				begin
					idx_next = idx_reg + 5'h01;
					if (idx_reg < 5'h0e)
					begin
						// payload byte
						data_next = {rx_byte, data_reg[111:8]};
						sum_next  = sum_reg + {8'h00, rx_byte};
					end
					else if (idx_reg == 5'h0e)
						crc_lo_next = rx_byte;  // checksum low byte
					else
					begin
						// last byte: accept only a good code and checksum
						state_next = sopg_pkg::SOPG_RX_IDLE;
						if (data_reg[`SOPG_P_CMD_LSB +: 32] == `SOPG_CMD_CODE
							&& crc_rx == sum_reg)
						begin
							load_next  = 1'b1;
							echo_next  = 3'h0;
							state_next = sopg_pkg::SOPG_RX_ECHO;
						end
					end
				end
			end
			sopg_pkg::SOPG_RX_ECHO:
			begin
				// incoming bytes are ignored until the echo is out
				if (tx_ready)
				begin
					echo_next = echo_reg + 3'h1;
					if (echo_reg == `SOPG_ANS_BYTES - 3'h1)
						state_next = sopg_pkg::SOPG_RX_IDLE;
				end
			end
			default:
				state_next = sopg_pkg::SOPG_RX_IDLE;
		endcase
		// answer registered so the pins come straight from flops
		tx_valid_next = (state_next == sopg_pkg::SOPG_RX_ECHO);
		tx_byte_next  = data_next[{echo_next[1:0], 3'h0} +: 8];
	end

	// registers of the receiver
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg  <= sopg_pkg::SOPG_RX_IDLE;
			idx_reg    <= 5'h00;
			sum_reg    <= 16'h0000;
			data_reg   <= 112'h0;
			crc_lo_reg <= 8'h00;
			echo_reg   <= 3'h0;
			load_reg   <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_byte_reg  <= 8'h00;
		end
		else
		begin
			state_reg  <= state_next;
			idx_reg    <= idx_next;
			sum_reg    <= sum_next;
			data_reg   <= data_next;
			crc_lo_reg <= crc_lo_next;
			echo_reg   <= echo_next;
			load_reg   <= load_next;
			tx_valid_reg <= tx_valid_next;
			tx_byte_reg  <= tx_byte_next;
		end
	end

	// answer: the command code, low byte first
	assign tx_valid   = tx_valid_reg;
	assign tx_byte    = tx_byte_reg;
	assign cfg_load   = load_reg;
	assign cfg_flags  = data_reg[`SOPG_P_FLAGS_LSB +: 8];
	assign cfg_width  = data_reg[`SOPG_P_WIDTH_LSB +: 16];
	assign cfg_period = data_reg[`SOPG_P_PERIOD_LSB +: 16];
	assign cfg_acc    = data_reg[`SOPG_P_ACC_LSB +: 32];
	assign cfg_uacc   = data_reg[`SOPG_P_UACC_LSB +: 8];

endmodule

// File: design/sopg_sync_out.sv
// sync output pulse generator top: settings store, triggers, width timer, pin
`timescale 1ns/1ns
`include "sopg_consts.svh"

module sopg_sync_out
(
	input  wire logic        clk_sys,          // system clock, 50 MHz
	input  wire logic        rst_n,            // async reset, active low
	input  wire logic [7:0]  rx_byte,          // settings frame byte
	input  wire logic        rx_valid,         // frame byte valid
	input  wire logic        rx_first,         // first byte of a frame
	output logic      [7:0]  tx_byte,          // echo byte
	output logic             tx_valid,         // echo byte valid
	input  wire logic        tx_ready,         // echo byte taken
	input  wire logic        move_active,      // a movement is in progress
	input  wire logic        step_pulse,       // one cycle per step or encoder pulse
	input  wire logic [31:0] position_whole,   // current position, whole steps
	input  wire logic [7:0]  position_micro,   // current position, microsteps
	input  wire logic [31:0] target_whole,     // target position, whole steps
	input  wire logic [7:0]  target_micro,     // target position, microsteps
	output logic             sync_out,         // sync output pin level
	output logic             pulse_active      // pulse in progress, true polarity
);

	localparam logic [5:0] US_CYCLES = 6'(`SOPG_US_CYCLES);   // cycles per microsecond

	logic [7:0]  cfg_flags;    // flag byte from the frame
	logic [15:0] cfg_width;    // width from the frame
	logic [15:0] cfg_period;   // period from the frame
	logic [31:0] cfg_acc;      // whole step window from the frame
	logic [7:0]  cfg_uacc;     // microstep window from the frame
	logic        cfg_load;     // frame accepted

	// frame receiver and echo
	sopg_frame_rx sopg_frame_rx_inst
	(
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.rx_byte    (rx_byte),
		.rx_valid   (rx_valid),
		.rx_first   (rx_first),
		.tx_byte    (tx_byte),
		.tx_valid   (tx_valid),
		.tx_ready   (tx_ready),
		.cfg_flags  (cfg_flags),
		.cfg_width  (cfg_width),
		.cfg_period (cfg_period),
		.cfg_acc    (cfg_acc),
		.cfg_uacc   (cfg_uacc),
		.cfg_load   (cfg_load)
	);

	// stored settings
	logic [7:0]  sync_output_flag_byte_reg, sync_output_flag_byte_next;   // flag byte
	logic [15:0] pulse_width_setting_reg, pulse_width_setting_next;   // width
	logic [15:0] pulse_period_count_reg, pulse_period_count_next;     // period
	logic [31:0] target_window_whole_reg, target_window_whole_next;   // window, steps
	logic [7:0]  target_window_microsteps_reg, target_window_microsteps_next;

	// settings store: replaced only by an accepted frame
	always_comb
	begin
		sync_output_flag_byte_next    = sync_output_flag_byte_reg;
		pulse_width_setting_next      = pulse_width_setting_reg;
		pulse_period_count_next       = pulse_period_count_reg;
		target_window_whole_next      = target_window_whole_reg;
		target_window_microsteps_next = target_window_microsteps_reg;
		if (cfg_load)
		begin
			sync_output_flag_byte_next    = cfg_flags;
			pulse_width_setting_next      = cfg_width;
			pulse_period_count_next       = cfg_period;
			target_window_whole_next      = cfg_acc;
			target_window_microsteps_next = cfg_uacc;
		end
	end

	// settings registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_output_flag_byte_reg    <= `SOPG_RST_FLAGS;
			pulse_width_setting_reg      <= `SOPG_RST_WIDTH;
			pulse_period_count_reg       <= `SOPG_RST_PERIOD;
			target_window_whole_reg      <= `SOPG_RST_ACC;
			target_window_microsteps_reg <= `SOPG_RST_UACC;
		end
		else
		begin
			sync_output_flag_byte_reg    <= sync_output_flag_byte_next;
			pulse_width_setting_reg      <= pulse_width_setting_next;
			pulse_period_count_reg       <= pulse_period_count_next;
			target_window_whole_reg      <= target_window_whole_next;
			target_window_microsteps_reg <= target_window_microsteps_next;
		end
	end

	// flag decode
	logic output_follows_logic;   // pin driven by the pulse logic
	logic fixed_output_level;     // pin level while not following
	logic active_low_select;      // low level is active
	logic width_in_steps_select;  // width counted in steps
	logic pulse_on_move_begin;    // pulse at movement start
	logic pulse_on_move_end;      // pulse at movement stop
	logic pulse_every_period;     // periodic pulses

	assign output_follows_logic  = sync_output_flag_byte_reg[`SOPG_F_FOLLOW];
	assign fixed_output_level    = sync_output_flag_byte_reg[`SOPG_F_FIXED_LEVEL];
	assign active_low_select     = sync_output_flag_byte_reg[`SOPG_F_ACTIVE_LOW];
	assign width_in_steps_select = sync_output_flag_byte_reg[`SOPG_F_IN_STEPS];
	assign pulse_on_move_begin   = sync_output_flag_byte_reg[`SOPG_F_ON_BEGIN];
	assign pulse_on_move_end     = sync_output_flag_byte_reg[`SOPG_F_ON_END];
	assign pulse_every_period    = sync_output_flag_byte_reg[`SOPG_F_ON_PERIOD];

	// target window compare on absolute differences
	logic [31:0] diff_whole;     // position minus target, whole steps
	logic [31:0] abs_whole;      // magnitude of the whole step error
	logic [8:0]  diff_micro;     // microstep error, signed
	logic [7:0]  abs_micro;      // magnitude of the microstep error
	logic        in_window;      // position counts as reached

	assign diff_whole = position_whole - target_whole;
	assign abs_whole  = diff_whole[31] ? (32'h0 - diff_whole) : diff_whole;
	assign diff_micro = {1'b0, position_micro} - {1'b0, target_micro};
	assign abs_micro  = diff_micro[8] ? 8'(9'h0 - diff_micro) : diff_micro[7:0];
	assign in_window  = (abs_whole < target_window_whole_reg)
		|| (abs_whole == target_window_whole_reg
		&& abs_micro <= target_window_microsteps_reg);

	// trigger and pulse timing state
	logic        move_d_reg, move_d_next;        // movement level one cycle ago
	logic        end_pend_reg, end_pend_next;    // movement ended, awaiting window
	logic [15:0] per_cnt_reg, per_cnt_next;      // steps since last periodic pulse
	logic [5:0]  us_div_reg, us_div_next;        // microsecond prescaler
	logic [15:0] width_cnt_reg, width_cnt_next;  // width units left
	logic        active_reg, active_next;        // pulse in progress
	logic        sync_out_reg, sync_out_next;    // pin level
	logic        trig_begin;                     // start trigger
	logic        trig_end;                       // stop trigger
	logic        trig_period;                    // periodic trigger
	logic        trigger;                        // any trigger
	logic        unit_tick;                      // one width unit elapsed
	logic        us_tick;                        // one microsecond elapsed

	assign trig_begin  = pulse_on_move_begin && move_active && !move_d_reg;
	assign trig_end    = pulse_on_move_end && end_pend_reg && in_window;
	assign trig_period = pulse_every_period && pulse_period_count_reg != 16'h0000
		&& step_pulse && per_cnt_reg + 16'h0001 >= pulse_period_count_reg;
	assign trigger     = trig_begin || trig_end || trig_period;
	assign us_tick     = (us_div_reg == US_CYCLES - 6'h01);
	assign unit_tick   = width_in_steps_select ? step_pulse : us_tick;

	// next values: triggers, width count and pin level
	always_comb
	begin
		move_d_next    = move_active;
		end_pend_next  = end_pend_reg;
		per_cnt_next   = per_cnt_reg;
		us_div_next    = us_tick ? 6'h00 : us_div_reg + 6'h01;
		width_cnt_next = width_cnt_reg;
		active_next    = active_reg;
		// stop waits for the window; a new start cancels it
		if (move_active && !move_d_reg)
			end_pend_next = 1'b0;
		else if (!move_active && move_d_reg)
			end_pend_next = 1'b1;
		else if (trig_end || !pulse_on_move_end)
			end_pend_next = 1'b0;
		// period counter only runs while periodic mode is on
		if (!pulse_every_period)
			per_cnt_next = 16'h0000;
		else if (trig_period)
			per_cnt_next = 16'h0000;
		else if (step_pulse)
			per_cnt_next = per_cnt_reg + 16'h0001;
		// width timer; a trigger mid pulse restarts it
		if (trigger)
		begin
			width_cnt_next = pulse_width_setting_reg;
			active_next    = pulse_width_setting_reg != 16'h0000;
			us_div_next    = 6'h00;
		end
		else if (active_reg && unit_tick)
		begin
			width_cnt_next = width_cnt_reg - 16'h0001;
			active_next    = width_cnt_reg != 16'h0001;
		end
		// pin: logic with polarity, or the fixed level
		if (output_follows_logic)
			sync_out_next = active_next ^ active_low_select;
		else
			sync_out_next = fixed_output_level;
	end

	// trigger and pulse registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			move_d_reg    <= 1'b0;
			end_pend_reg  <= 1'b0;
			per_cnt_reg   <= 16'h0000;
			us_div_reg    <= 6'h00;
			width_cnt_reg <= 16'h0000;
			active_reg    <= 1'b0;
			sync_out_reg  <= 1'b0;
		end
		else
		begin
			move_d_reg    <= move_d_next;
			end_pend_reg  <= end_pend_next;
			per_cnt_reg   <= per_cnt_next;
			us_div_reg    <= us_div_next;
			width_cnt_reg <= width_cnt_next;
			active_reg    <= active_next;
			sync_out_reg  <= sync_out_next;
		end
	end

	assign sync_out     = sync_out_reg;
	assign pulse_active = active_reg;

endmodule

// File: verification/sopg_sync_out_checker.sv
// port-level assertions for the sync output pulse generator
`timescale 1ns/1ns
module sopg_sync_out_checker
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [7:0] rx_byte,
	input wire logic       rx_valid,
	input wire logic       rx_first,
	input wire logic [7:0] tx_byte,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       move_active,
	input wire logic       step_pulse,
	input wire logic       sync_out,
	input wire logic       pulse_active
);
	logic [7:0]  pb [0:15]; // snooped frame bytes
	logic [3:0]  idx;       // next byte slot, 0 when idle
	logic [7:0]  cf;        // flags of the last echoed frame
	logic [15:0] cw;        // width of the last echoed frame
	logic        tv_q;      // tx_valid one cycle ago
	// snoop frames, commit settings once the echo starts
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			idx  <= 4'h0;
			cf   <= 8'h00;
			cw   <= 16'h0000;
			tv_q <= 1'b0;
		end
		else
		begin
			tv_q <= tx_valid;
			if (rx_valid && rx_first)
			begin
				pb[0] <= rx_byte;
				idx   <= 4'h1;
			end
			else if (rx_valid && idx != 4'h0)
			begin
				pb[idx] <= rx_byte;
				idx     <= idx + 4'h1;
			end
			if (tx_valid && !tv_q)
			begin
				cf <= pb[4];
				cw <= {pb[6], pb[5]};
			end
		end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_echo_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("echo byte not held");
	a_echo_first: assert property ($rose(tx_valid) |-> tx_byte == 8'h73)
		else $error("echo does not open with the code");
	a_echo_end: assert property (tx_valid && tx_ready && tx_byte == 8'h6f |=> !tx_valid)
		else $error("echo longer than four bytes");
	a_fixed_level: assert property (!cf[0] && $stable(cf) |-> sync_out == cf[1])
		else $error("pin not at fixed level");
	a_pin_polarity: assert property (cf[0] && $stable(cf) |-> sync_out == (pulse_active ^ cf[2]))
		else $error("pin level does not match pulse and polarity");
	a_start_pulse: assert property (cf[0] && cf[4] && cw != 16'h0 && $stable(cf)
		&& $rose(move_active) |=> pulse_active) else $error("no pulse on movement begin");
	a_zero_width: assert property (cw == 16'h0 && $stable(cw) && !$past(pulse_active)
		|-> !pulse_active) else $error("pulse with zero width");
	a_step_hold: assert property (cf[3] && $stable(cf) && !tx_valid && pulse_active
		&& !step_pulse |=> pulse_active) else $error("step pulse ended without a step");
	a_quiet_off: assert property (cf[6:4] == 3'h0 && $stable(cf) && !tx_valid
		|=> !$rose(pulse_active)) else $error("pulse with all triggers off");
	c_echo: cover property ($rose(tx_valid));
	c_step_end: cover property (cf[3] && $fell(pulse_active));
	c_low_active: cover property (cf[2] && pulse_active && !sync_out);
endmodule

bind sopg_sync_out sopg_sync_out_checker sopg_sync_out_checker_inst
(
	.clk_sys      (clk_sys),
	.rst_n        (rst_n),
	.rx_byte      (rx_byte),
	.rx_valid     (rx_valid),
	.rx_first     (rx_first),
	.tx_byte      (tx_byte),
	.tx_valid     (tx_valid),
	.tx_ready     (tx_ready),
	.move_active  (move_active),
	.step_pulse   (step_pulse),
	.sync_out     (sync_out),
	.pulse_active (pulse_active)
);

// File: verification/sopg_host_model.sv
// host model: sends settings frames and takes the echo bytes
`timescale 1ns/1ns
module sopg_host_model
(
	input  wire logic       clk_sys,  // system clock
	output logic      [7:0] rx_byte,  // frame byte
	output logic            rx_valid, // byte valid
	output logic            rx_first, // first byte of a frame
	input  wire logic [7:0] tx_byte,  // echo byte
	input  wire logic       tx_valid, // echo byte offered
	output logic            tx_ready  // echo byte taken
);
	logic [7:0] got_q [$];    // echo bytes taken
	bit         slow = 1'b0;  // stall every other cycle
	initial
	begin
		rx_byte  = 8'h00;
		rx_valid = 1'b0;
		rx_first = 1'b0;
	end
	// ready prompt, or toggling to stall the echo
	always @(negedge clk_sys)
		tx_ready <= slow ? ~tx_ready : 1'b1;
	// record each echo byte at the edge it is taken
	always @(posedge clk_sys)
		if (tx_valid && tx_ready)
			got_q.push_back(tx_byte);
	// one frame back to back; bad spoils the checksum
	task automatic send(input logic [7:0] fl, input logic [15:0] w, input logic [15:0] p,
		input logic [31:0] acc, input logic [7:0] uacc, input bit bad);
		logic [7:0]  b [0:15];
		logic [15:0] sum;
		{b[3], b[2], b[1], b[0]} = 32'h6f6e7373;
		b[4] = fl;
		{b[6], b[5]} = w;
		{b[8], b[7]} = p;
		{b[12], b[11], b[10], b[9]} = acc;
		b[13] = uacc;
		sum = 16'h0000;
		for (int i = 0; i < 14; i++)
			sum = sum + {8'h00, b[i]};
		{b[15], b[14]} = sum ^ {15'h0000, bad};
		for (int i = 0; i < 16; i++)
		begin
			@(negedge clk_sys);
			rx_first <= (i == 0);
			rx_valid <= 1'b1;
			rx_byte  <= b[i];
		end
		@(negedge clk_sys);
		rx_first <= 1'b0;
		rx_valid <= 1'b0;
		rx_byte  <= ~b[15];
	endtask
endmodule

// File: verification/sopg_sync_out_bench.sv
// self-checking bench for the sync output pulse generator
`timescale 1ns/1ns
module sopg_sync_out_bench;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  rx_byte, tx_byte;
	logic        rx_valid, rx_first, tx_valid, tx_ready, sync_out, pulse_active;
	logic        move_active = 1'b0;
	logic        step_pulse = 1'b0;
	logic [31:0] pos_w = 32'h0, tgt_w = 32'h0;
	logic [7:0]  pos_m = 8'h00, tgt_m = 8'h00;   // microstep position and target
	logic [15:0] seed = 16'hc3c8;   // lfsr state
	int          errors = 0, cmp_count = 0, cycles = 0, n, w, p;
	int          exp_q [$];         // model of the echo
	sopg_sync_out sopg_sync_out_inst
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.rx_first(rx_first), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.move_active(move_active), .step_pulse(step_pulse), .position_whole(pos_w),
		.position_micro(pos_m), .target_whole(tgt_w), .target_micro(tgt_m),
		.sync_out(sync_out), .pulse_active(pulse_active)
	);
	sopg_host_model sopg_host_model_inst
	(
		.clk_sys(clk_sys), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready)
	);
	initial
		forever #10 clk_sys = ~clk_sys;
	// hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			end_of_test();
		end
	end
	function automatic int rnd(input int lo, input int span);
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return lo + int'(seed) % span;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// send settings and compare the echo with the model
	task automatic cfg(input logic [7:0] fl, input int wd, input int pd, input int acc,
		input int uacc);
		int k;
		sopg_host_model_inst.send(fl, wd[15:0], pd[15:0], acc, uacc[7:0], 1'b0);
		exp_q = '{8'h73, 8'h73, 8'h6e, 8'h6f};
		for (k = 0; k < 100 && sopg_host_model_inst.got_q.size() < 4; k++)
			@(negedge clk_sys);
		check(sopg_host_model_inst.got_q.size(), 4);
		foreach (exp_q[i])
			check(sopg_host_model_inst.got_q[i], exp_q[i]);
		sopg_host_model_inst.got_q.delete();
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic steps(input int k);
		repeat (k)
		begin
			@(negedge clk_sys);
			step_pulse = 1'b1;
			@(negedge clk_sys);
			step_pulse = 1'b0;
		end
	endtask
	// wait for a pulse, then count its cycles
	task automatic measure(output int len);
		int k;
		len = 0;
		for (k = 0; k < 60 && pulse_active !== 1'b1; k++)
			@(negedge clk_sys);
		while (pulse_active === 1'b1 && len < 1000)
		begin
			@(negedge clk_sys);
			len++;
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		check(sync_out, 0);
		sopg_host_model_inst.slow = 1'b1;
		cfg(8'h12, 1, 0, 0, 0);
		move_active = 1'b1;
		repeat (3) @(negedge clk_sys);
		check(sync_out, 1);
		move_active = 1'b0;
		sopg_host_model_inst.send(8'h00, 16'h1, 16'h0, 32'h0, 8'h00, 1'b1);
		repeat (30) @(negedge clk_sys);
		check(sopg_host_model_inst.got_q.size(), 0);
		check(sync_out, 1);
		sopg_host_model_inst.slow = 1'b0;
		for (int inv = 0; inv < 8; inv += 4)
		begin
			w = rnd(1, 3);
			cfg(8'h11 | inv[7:0], w, 0, 0, 0);
			check(sync_out, inv / 4);
			move_active = 1'b1;
			measure(n);
			check(n, w * 50);
			move_active = 1'b0;
		end
		p = rnd(2, 3);
		cfg(8'h41, 2, p, 0, 0);
		fork
			steps(p);
			measure(n);
		join
		check(n, 100);
		fork
			steps(2 * p);
			measure(n);
		join
		check(n, 2 * p + 100);
		cfg(8'h01, 2, p, 0, 0);
		fork
			steps(2 * p);
			measure(n);
		join
		check(n, 0);
		cfg(8'h29, 3, 0, 2, 4);
		tgt_w = rnd(0, 1000);
		pos_w = tgt_w + 5;
		move_active = 1'b1;
		repeat (3) @(negedge clk_sys);
		move_active = 1'b0;
		repeat (10) @(negedge clk_sys);
		check(pulse_active, 0);
		// on the whole step edge the microstep error decides
		pos_w = tgt_w + 2;
		pos_m = 8'h10;
		tgt_m = 8'h08;
		repeat (10) @(negedge clk_sys);
		check(pulse_active, 0);
		pos_m = 8'h0b;
		repeat (30) @(negedge clk_sys);
		check(pulse_active, 1);
		steps(2);
		check(pulse_active, 1);
		steps(1);
		repeat (2) @(negedge clk_sys);
		check(pulse_active, 0);
		end_of_test();
	end
endmodule
